//--- verilog/hpac_consts.vh
/*
   Constants for the headphone amplifier mode control block: register
   indices, field positions, reset values and mode codes.
   Assumes inclusion by bare name from the design files.
*/
`ifndef HPAC_CONSTS_VH
`define HPAC_CONSTS_VH

// ****************************************
// Register indices
// ****************************************
`define HPAC_ADDR_MAIN 8'h01
`define HPAC_ADDR_VOL 8'h02
`define HPAC_ADDR_FLOAT 8'h03
`define HPAC_ADDR_STATUS 8'h04

// ****************************************
// Field positions
// ****************************************
`define HPAC_MAIN_SLP 0
`define HPAC_MAIN_MODE_LO 4
`define HPAC_MAIN_MODE_HI 5
`define HPAC_MAIN_EN_L 7
`define HPAC_MAIN_EN_R 6
`define HPAC_FLOAT_L 0
`define HPAC_FLOAT_R 1
`define HPAC_VOL_MUTE_L 7
`define HPAC_VOL_MUTE_R 6
`define HPAC_STAT_THERM 0

// ****************************************
// Reset values and mode codes
// ****************************************
`define HPAC_MAIN_RST 8'h00
`define HPAC_VOL_RST 8'hC0
`define HPAC_FLOAT_RST 8'h00
`define HPAC_MODE_STEREO 2'h0
`define HPAC_MODE_DUALMONO 2'h1
`define HPAC_MODE_BRIDGE 2'h2

`endif

//--- verilog/hpac_route.v
/*
   Output routing decode: from mode, enables and float bits to the
   per-output drive, source and float controls.
   Assumes the caller has already folded shutdown into the enables.
*/
`timescale 1ns/1ns
`include "hpac_consts.vh"

module hpac_route
(
   input wire [1:0] mode_i,
   input wire en_l_i,
   input wire en_r_i,
   input wire float_l_i,
   input wire float_r_i,
   output reg drive_l_o,
   output reg drive_r_o,
   output reg src_r_left_o,
   output reg invert_r_o,
   output reg float_l_o,
   output reg float_r_o
);

   // ****************************************
   // Combinational routing
   // ****************************************
   always @*
   begin
      drive_l_o = en_l_i;
      drive_r_o = en_r_i;
      src_r_left_o = 1'b0;
      invert_r_o = 1'b0;
      // Enabled amp overrides its float bit
      float_l_o = float_l_i & ~en_l_i;
      float_r_o = float_r_i & ~en_r_i;
      // Modes only apply with both enables set
      if (en_l_i && en_r_i)
      begin
         case (mode_i)
            `HPAC_MODE_STEREO: src_r_left_o = 1'b0;
            `HPAC_MODE_DUALMONO: src_r_left_o = 1'b1;
            `HPAC_MODE_BRIDGE:
            begin
               src_r_left_o = 1'b1;
               invert_r_o = 1'b1;
            end
            default: src_r_left_o = 1'b0;
         endcase
      end
   end

endmodule // hpac_route

//--- verilog/hpac_ctrl.v
/*
   Headphone amplifier mode control: register bank written by the
   serial host, shutdown handling, thermal record and output control.

   Register map, one byte per index:
      1  main control: bit 7 left enable, bit 6 right enable,
         bits 5:4 output mode, bit 0 soft low power
      2  gain: bit 7 left mute, bit 6 right mute, bits 5:0 volume
         code shared by both channels
      3  output float: bit 0 left, bit 1 right
      4  status, read only: bit 0 thermal fault record
   Writes to the status index and to unmapped indices are ignored;
   unmapped indices read back as zero.
   Mode 11 is not a documented mode and behaves as stereo.
   A thermal fault sleeps the device like soft low power, but the
   enable bits stay as written, so the host sees what it asked for.

   Assumes a byte-wide write/read port already decoded from the serial
   bus, synchronous to sys_clk_i, and a synchronous thermal flag.
   The shutdown pin is sampled like a synchronous reset, so it must be
   held low for at least one clock edge to take effect.
*/
// Overview of operation
// - Low shutdown pin forces every function off.
// - Hardware shutdown overrides all register settings.
// - Hardware shutdown returns every register to its default.
// - Writing 1 to main control bit 0 enters soft low power.
// - Soft low power stops the charge pump and both outputs.
// - Writing 0 to that bit returns to normal operation.
// - Entering soft low power clears enable bits 7 and 6 only.
// - Bits 7 and 6 enable left and right amps independently.
// - Charge pump stays on with both amps off unless shut down.
// - Float register bits 0 and 1 float left and right outputs.
// - Mode 00 with both enabled gives stereo.
// - Mode 01 with both enabled sends left input to both outputs.
// - Mode 10 with both enabled bridges left input across outputs.
// - Power-up defaults: awake, pump on, amps off, stereo, muted, -59.5 dB.
// - Overtemperature shuts device down and sets a readable status bit.
// - Gain register: two mute bits above a six-bit volume code.
`timescale 1ns/1ns
`include "hpac_consts.vh"

module hpac_ctrl
(
   input wire sys_clk_i,
   input wire srst_i,
   input wire hw_off_pin_n_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire over_temp_i,
   output reg [7:0] rdata_o,
   output reg rvalid_o,
   output reg pump_on_o,
   output reg left_output_drive_o,
   output reg right_output_drive_o,
   output reg left_output_float_o,
   output reg right_output_float_o,
   output reg right_from_left_o,
   output reg right_invert_o,
   output reg left_silence_o,
   output reg right_silence_o,
   output reg [5:0] left_vol_o,
   output reg [5:0] right_vol_o,
   output reg thermal_fault_o
);

   // ****************************************
   // Register bank
   // ****************************************
   reg [7:0] main_reg;
   reg [7:0] float_reg;
   reg [7:0] vol_reg;
   reg therm_reg;
   wire hw_off;
   wire slp;
   wire en_l;
   wire en_r;
   wire drv_l;
   wire drv_r;
   wire src_rl;
   wire inv_r;
   wire flt_l;
   wire flt_r;
   reg [7:0] main_next;
   reg [7:0] float_next;
   reg [7:0] vol_next;
   reg therm_next;
   wire wr_main;
   wire wr_float;
   wire wr_vol;
   reg pump_next;
   reg drive_l_next;
   reg drive_r_next;
   reg float_l_next;
   reg float_r_next;
   reg from_left_next;
   reg invert_next;
   reg silence_l_next;
   reg silence_r_next;
   reg [5:0] vol_l_next;
   reg [5:0] vol_r_next;
   reg fault_next;
   reg rvalid_next;
   reg [7:0] rdata_next;

   // Shutdown pin acts as an extra reset
   assign hw_off = srst_i | ~hw_off_pin_n_i;
   assign slp = main_reg[`HPAC_MAIN_SLP] | therm_reg;

   // Shutdown folds into the enables before routing
   assign en_l = main_reg[`HPAC_MAIN_EN_L] & ~slp;
   assign en_r = main_reg[`HPAC_MAIN_EN_R] & ~slp;

   // ****************************************
   // Helper functions
   // ****************************************
   // Write strobe decode shared by every writable register
   function wr_hit;
      input wr_en;
      input [7:0] addr;
      input [7:0] index;
      begin
         wr_hit = wr_en & (addr == index);
      end
   endfunction

   // Both channel enables dropped, every other bit of the word kept
   function [7:0] drop_enables;
      input [7:0] word;
      begin
         drop_enables = word;
         drop_enables[`HPAC_MAIN_EN_L] = 1'b0;
         drop_enables[`HPAC_MAIN_EN_R] = 1'b0;
      end
   endfunction

   // Float request gated by the awake state, applied per output
   function awake_only;
      input request;
      input sleeping;
      begin
         awake_only = request & ~sleeping;
      end
   endfunction

   // Read-back word for a register index; unmapped indices read zero
   function [7:0] read_word;
      input [7:0] addr;
      input [7:0] main_word;
      input [7:0] vol_word;
      input [7:0] float_word;
      input therm_bit;
      begin
         case (addr)
            `HPAC_ADDR_MAIN: read_word = main_word;
            `HPAC_ADDR_VOL: read_word = vol_word;
            `HPAC_ADDR_FLOAT: read_word = float_word;
            `HPAC_ADDR_STATUS: read_word = {7'h00, therm_bit};
            default: read_word = 8'h00;
         endcase
      end
   endfunction

   // ****************************************
   // Register next values
   // ****************************************
   // Status index is read-only, so writes to it fall through
   assign wr_main = wr_hit(wr_en_i, addr_i, `HPAC_ADDR_MAIN);
   assign wr_float = wr_hit(wr_en_i, addr_i, `HPAC_ADDR_FLOAT);
   assign wr_vol = wr_hit(wr_en_i, addr_i, `HPAC_ADDR_VOL);

   // Host writes land at the strobe edge; soft sleep keeps enables clear
   always @*
   begin
      main_next = main_reg;
      float_next = float_reg;
      vol_next = vol_reg;
      therm_next = therm_reg;
      if (wr_main)
      begin
         // Whole-word write, enables dropped when bit 0 is set; the only way back out of soft sleep short of shutdown
         main_next = wdata_i;
         if (wdata_i[`HPAC_MAIN_SLP])
            main_next = drop_enables(wdata_i);
      end
      else if (main_reg[`HPAC_MAIN_SLP])
         main_next = drop_enables(main_reg);
      if (wr_float)
         float_next = wdata_i;
      if (wr_vol)
         vol_next = wdata_i;
      // Thermal record is sticky; only shutdown clears it
      if (over_temp_i)
         therm_next = 1'b1;
   end

   // ****************************************
   // Register state
   // ****************************************
   // Register contents lost on hardware shutdown
   always @(posedge sys_clk_i)
   begin
      if (hw_off)
      begin
         main_reg <= `HPAC_MAIN_RST;
         float_reg <= `HPAC_FLOAT_RST;
         vol_reg <= `HPAC_VOL_RST;
         therm_reg <= 1'b0;
      end
      else
      begin
         main_reg <= main_next;
         float_reg <= float_next;
         vol_reg <= vol_next;
         therm_reg <= therm_next;
      end
   end

   // ****************************************
   // Routing decode
   // ****************************************
   hpac_route u_route
   (
      .mode_i(main_reg[`HPAC_MAIN_MODE_HI:`HPAC_MAIN_MODE_LO]),
      .en_l_i(en_l),
      .en_r_i(en_r),
      .float_l_i(float_reg[`HPAC_FLOAT_L]),
      .float_r_i(float_reg[`HPAC_FLOAT_R]),
      .drive_l_o(drv_l),
      .drive_r_o(drv_r),
      .src_r_left_o(src_rl),
      .invert_r_o(inv_r),
      .float_l_o(flt_l),
      .float_r_o(flt_r)
   );

   // ****************************************
   // Output next values
   // ****************************************
   // Shutdown wins over everything the registers ask for
   always @*
   begin
      pump_next = ~slp;
      drive_l_next = drv_l;
      drive_r_next = drv_r;
      // Float honoured only while awake
      float_l_next = awake_only(flt_l, slp);
      float_r_next = awake_only(flt_r, slp);
      from_left_next = src_rl;
      invert_next = inv_r;
      silence_l_next = vol_reg[`HPAC_VOL_MUTE_L];
      silence_r_next = vol_reg[`HPAC_VOL_MUTE_R];
      // One shared volume code for both channels
      vol_l_next = vol_reg[5:0];
      vol_r_next = vol_reg[5:0];
      fault_next = therm_reg;
      // Read answer one cycle after the strobe; data follows addr_i
      rvalid_next = rd_en_i;
      rdata_next = read_word(addr_i, main_reg, vol_reg, float_reg, therm_reg);
      if (hw_off)
      begin
         // Quietest state: pump and amps off, both channels muted
         pump_next = 1'b0;
         drive_l_next = 1'b0;
         drive_r_next = 1'b0;
         float_l_next = 1'b0;
         float_r_next = 1'b0;
         from_left_next = 1'b0;
         invert_next = 1'b0;
         silence_l_next = 1'b1;
         silence_r_next = 1'b1;
         vol_l_next = 6'h00;
         vol_r_next = 6'h00;
         fault_next = 1'b0;
         rvalid_next = 1'b0;
         rdata_next = 8'h00;
      end
   end

   // ****************************************
   // Registered outputs
   // ****************************************
   // Every output straight from a flop, so pins never glitch on decode
   always @(posedge sys_clk_i)
   begin
      pump_on_o <= pump_next;
      left_output_drive_o <= drive_l_next;
      right_output_drive_o <= drive_r_next;
      left_output_float_o <= float_l_next;
      right_output_float_o <= float_r_next;
      right_from_left_o <= from_left_next;
      right_invert_o <= invert_next;
      left_silence_o <= silence_l_next;
      right_silence_o <= silence_r_next;
      left_vol_o <= vol_l_next;
      right_vol_o <= vol_r_next;
      thermal_fault_o <= fault_next;
      rvalid_o <= rvalid_next;
      rdata_o <= rdata_next;
   end

endmodule // hpac_ctrl

//--- verification/hpac_ctrl_properties.sv
/* Port checker for hpac_ctrl.
   Assumes it is bound to every hpac_ctrl instance by the bind below. */
`timescale 1ns/1ns
module hpac_ctrl_chk
(
   input wire sys_clk_i,
   input wire srst_i,
   input wire hw_off_pin_n_i,
   input wire wr_en_i,
   input wire rd_en_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   input wire over_temp_i,
   input wire rvalid_o,
   input wire pump_on_o,
   input wire left_output_drive_o,
   input wire right_output_drive_o,
   input wire left_output_float_o,
   input wire right_output_float_o,
   input wire right_from_left_o,
   input wire right_invert_o,
   input wire left_silence_o,
   input wire right_silence_o,
   input wire [5:0] left_vol_o,
   input wire thermal_fault_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   // Awake main write with no other main write or fault right behind it
   sequence main_wr;
      wr_en_i && addr_i == 8'h01 && !wdata_i[0] && hw_off_pin_n_i && !over_temp_i
         && !thermal_fault_o && !$past(over_temp_i) ##1 hw_off_pin_n_i && !over_temp_i
         && !(wr_en_i && addr_i == 8'h01);
   endsequence
   AST_HW_OFF: assert property (!hw_off_pin_n_i |=>
      !pump_on_o && !left_output_drive_o && !right_output_drive_o && left_silence_o
      && right_silence_o && left_vol_o == 6'h00 && !thermal_fault_o)
      else $error("pin shutdown left something on");
   AST_SOFT_OFF: assert property (wr_en_i && addr_i == 8'h01 && wdata_i[0]
      && hw_off_pin_n_i |=> ##1 !pump_on_o && !left_output_drive_o && !right_output_drive_o)
      else $error("soft low power left pump or amp on");
   AST_ENABLES: assert property (main_wr |=> pump_on_o
      && left_output_drive_o == $past(wdata_i[7], 2)
      && right_output_drive_o == $past(wdata_i[6], 2))
      else $error("enables do not follow main write");
   AST_MODE: assert property (main_wr |=> $past(wdata_i[7:6], 2) == 2'h3 |->
      right_from_left_o == ($past(wdata_i[5:4], 2) inside {2'h1, 2'h2})
      && right_invert_o == ($past(wdata_i[5:4], 2) == 2'h2))
      else $error("routing does not match mode");
   AST_THERM: assert property (over_temp_i && hw_off_pin_n_i ##1 hw_off_pin_n_i |=>
      thermal_fault_o && !pump_on_o && !left_output_drive_o)
      else $error("overtemperature not recorded");
   AST_FLOAT: assert property (!(left_output_drive_o && left_output_float_o)
      && !(right_output_drive_o && right_output_float_o))
      else $error("driven output also floating");
   AST_RD_ANS: assert property (rd_en_i && hw_off_pin_n_i |=> rvalid_o)
      else $error("read gave no answer");
   AST_RD_IDLE: assert property (!rd_en_i |=> !rvalid_o)
      else $error("answer without read");
   // Main scenarios reached
   cover property (main_wr);
   cover property (thermal_fault_o);
   cover property (left_output_drive_o && right_output_float_o);
endmodule // hpac_ctrl_chk
bind hpac_ctrl hpac_ctrl_chk i_chk (.*);

//--- verification/hpac_host.sv
/* Serial host model: one strobed byte access per call.
   Assumes the device samples strobes on the rising edge. */
`timescale 1ns/1ns
module hpac_host
(
   input wire sys_clk_i,
   output reg wr_en_o,
   output reg rd_en_o,
   output reg [7:0] addr_o,
   output reg [7:0] wdata_o,
   input wire [7:0] rdata_i
);
   // Strobes idle low from time zero
   initial
   begin
      wr_en_o = 1'b0;
      rd_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end
   // Hold the request for one edge, then take the answer
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      begin
         @(posedge sys_clk_i);
         #1;
         wr_en_o = w;
         rd_en_o = !w;
         addr_o = a;
         wdata_o = d;
         @(posedge sys_clk_i);
         #1;
         wr_en_o = 1'b0;
         rd_en_o = 1'b0;
         wdata_o = ~d; // Stale data must not look valid
         q = rdata_i;
      end
   endtask
endmodule // hpac_host

//--- verification/test_headphone_amp_mode_control.sv
/* Self-checking bench for hpac_ctrl.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ns
module test_headphone_amp_mode_control;
   reg sys_clk_i = 1'b0;
   reg srst_i = 1'b1;
   reg hw_off_pin_n_i = 1'b1;
   reg over_temp_i = 1'b0;
   wire wr_en_i, rd_en_i, rvalid_o, pump_on_o, thermal_fault_o, right_from_left_o;
   wire left_output_drive_o, right_output_drive_o, left_output_float_o;
   wire right_output_float_o, right_invert_o, left_silence_o, right_silence_o;
   wire [7:0] addr_i, wdata_i, rdata_o;
   wire [5:0] left_vol_o, right_vol_o;
   wire [7:0] outs = {pump_on_o, left_output_drive_o, right_output_drive_o,
      left_output_float_o, right_output_float_o, right_from_left_o, right_invert_o,
      thermal_fault_o};
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [7:0] q;
   logic [1:0] m;
   always #5 sys_clk_i = ~sys_clk_i;
   hpac_ctrl i_dut (.*);
   hpac_host i_host (.sys_clk_i(sys_clk_i), .wr_en_o(wr_en_i), .rd_en_o(rd_en_i),
      .addr_o(addr_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      begin
         n_checks++;
         if (seen !== exp)
         begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", n_checks, num_errors);
         if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      i_host.acc(1'b1, a, d, q);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      begin
         i_host.acc(1'b0, a, 8'h00, q);
         chk(q, e);
         chk({7'h00, rvalid_o}, 8'h01);
      end
   endtask
   // Outputs settle one edge after the register
   task st(input logic [7:0] e);
      begin
         repeat (2) @(posedge sys_clk_i);
         #1;
         chk(outs, e);
      end
   endtask
   // Hang guard; the tests need well under a thousand cycles
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         num_errors++;
         wrap_up;
      end
   end
   initial
   begin
      repeat (5) @(posedge sys_clk_i);
      #1;
      srst_i = 1'b0;
      st(8'h80);
      chk({left_silence_o, right_silence_o, left_vol_o}, 8'hC0);
      chk({2'h0, right_vol_o}, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'hC0);
      rd(8'h03, 8'h00);
      rd(8'h07, 8'h00);
      wr(8'h02, 8'h65);
      rd(8'h02, 8'h65);
      chk({left_silence_o, right_silence_o, left_vol_o}, 8'h65);
      chk({2'h0, right_vol_o}, 8'h25);
      // Mode codes 00, 01 and 10 with both amps on
      for (m = 2'h0; m != 2'h3; m++)
      begin
         wr(8'h01, {2'h3, m, 4'h0});
         st({5'h1C, m == 2'h1 || m == 2'h2, m == 2'h2, 1'b0});
      end
      // Mode 11 falls back to stereo
      wr(8'h01, 8'hF0);
      st(8'hE0);
      // Bridge code with one amp only leaves routing alone
      wr(8'h01, 8'hA0);
      st(8'hC0);
      wr(8'h01, 8'h80);
      st(8'hC0);
      wr(8'h01, 8'h40);
      st(8'hA0);
      wr(8'h01, 8'h00);
      st(8'h80);
      wr(8'h03, 8'h03);
      st(8'h98);
      wr(8'h01, 8'h80);
      st(8'hC8);
      wr(8'h01, 8'hC1);
      st(8'h00);
      rd(8'h01, 8'h01);
      rd(8'h03, 8'h03);
      wr(8'h01, 8'hC0);
      st(8'hE0);
      over_temp_i = 1'b1;
      @(posedge sys_clk_i);
      #1;
      over_temp_i = 1'b0;
      st(8'h01);
      rd(8'h04, 8'h01);
      hw_off_pin_n_i = 1'b0;
      wr(8'h01, 8'hC0);
      st(8'h00);
      hw_off_pin_n_i = 1'b1;
      rd(8'h01, 8'h00);
      rd(8'h02, 8'hC0);
      rd(8'h04, 8'h00);
      st(8'h80);
      wrap_up;
   end
endmodule // test_headphone_amp_mode_control
